// >>> dram_cmd_addr_decode.sv
// command and address input stage: sampling, command decode, address routing
module dram_cmd_addr_decode
  import dram_cmd_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  output logic act_o,
  output logic rd_o,
  output logic wr_o,
  output logic pre_o,
  output logic pre_all_o,
  output logic mrs_o,
  output logic ref_o,
  output logic zq_o,
  output logic [2:0] bank_o,
  output logic [ADDR_W-1:0] row_o,
  output logic [ADDR_W-3:0] col_o,
  output logic auto_pre_o,
  output logic burst8_o,
  output logic [1:0] mr_sel_o,
  output logic [ADDR_W-1:0] opcode_o,
  output logic [1:0] burst_mode_o,
  output logic pdown_o,
  output logic sref_o,
  output logic dqs_o,
  output logic dqs_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input sampling
  logic cke_r, cke_prev_r, cs_n_r, ras_n_r, cas_n_r, we_n_r;
  logic [2:0] ba_r;
  logic [ADDR_W-1:0] addr_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_r <= 1'b0;
      cke_prev_r <= 1'b0;
      cs_n_r <= 1'b1;
      ras_n_r <= 1'b1;
      cas_n_r <= 1'b1;
      we_n_r <= 1'b1;
      ba_r <= 3'h0;
      addr_r <= '0;
    end else begin
      cke_r <= cke_i;
      cke_prev_r <= cke_r;
      cs_n_r <= cs_n_i;
      ras_n_r <= ras_n_i;
      cas_n_r <= cas_n_i;
      we_n_r <= we_n_i;
      ba_r <= ba_i;
      addr_r <= addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state
  pwr_state_e state_r, state_nxt;
  wire [2:0] cmd = {ras_n_r, cas_n_r, we_n_r};
  wire cke_fall = cke_prev_r & ~cke_r;
  wire sref_entry = cke_fall & ~cs_n_r & (cmd == CMD_REF);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (sref_entry) begin
          state_nxt = ST_SREF;
        end else if (cke_fall) begin
          state_nxt = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        if (cke_r) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_SREF: begin
        // exit looks at the pin directly, not at the sampled enable
        if (cke_i) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and address routing
  wire cmd_ok = (state_r == ST_ACTIVE) & cke_prev_r & cke_r & ~cs_n_r;
  wire is_act = cmd_ok & (cmd == CMD_ACT);
  wire is_rd = cmd_ok & (cmd == CMD_RD);
  wire is_wr = cmd_ok & (cmd == CMD_WR);
  wire is_pre = cmd_ok & (cmd == CMD_PRE);
  wire is_mrs = cmd_ok & (cmd == CMD_MRS);
  wire is_ref = cmd_ok & (cmd == CMD_REF);
  wire is_zq = cmd_ok & (cmd == CMD_ZQ);
  wire is_rw = is_rd | is_wr;
  wire banked = is_act | is_rw | is_pre;
  wire [ADDR_W-3:0] col_sel = {addr_r[ADDR_W-1], addr_r[BC_BIT-1], addr_r[AP_BIT-1:0]};

  logic [15:0] mr_r [4];
  wire [1:0] bl_field = mr_r[0][MR0_BL_LSB+1:MR0_BL_LSB];
  wire bl8_sel = (bl_field == BL_OTF) ? addr_r[BC_BIT] : (bl_field != BL_FIXED4);
  wire mr_write = is_mrs & ~ba_r[2];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        mr_r[i] <= MR_RESET;
      end
    end else if (mr_write) begin
      mr_r[ba_r[1:0]] <= 16'(addr_r);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_o <= 1'b0;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      pre_o <= 1'b0;
      mrs_o <= 1'b0;
      ref_o <= 1'b0;
      zq_o <= 1'b0;
    end else begin
      act_o <= is_act;
      rd_o <= is_rd;
      wr_o <= is_wr;
      pre_o <= is_pre;
      mrs_o <= mr_write;
      ref_o <= is_ref;
      zq_o <= is_zq;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_o <= 3'h0;
      row_o <= '0;
      col_o <= '0;
      auto_pre_o <= 1'b0;
      burst8_o <= 1'b1;
      pre_all_o <= 1'b0;
      mr_sel_o <= 2'h0;
      opcode_o <= '0;
    end else begin
      if (banked) begin
        bank_o <= ba_r;
      end
      if (is_act) begin
        row_o <= addr_r;
      end
      if (is_rw) begin
        col_o <= col_sel;
        auto_pre_o <= addr_r[AP_BIT];
        burst8_o <= bl8_sel;
      end
      if (is_pre) begin
        pre_all_o <= addr_r[AP_BIT];
      end
      if (mr_write) begin
        mr_sel_o <= ba_r[1:0];
        opcode_o <= addr_r;
      end
    end
  end

  assign burst_mode_o = bl_field;
  assign pdown_o = (state_r == ST_PDOWN);
  assign sref_o = (state_r == ST_SREF);

  ////////////////////////////////////////////////////////////////////////////
  // read strobe: launched on clock edges, one toggle per clock
  logic [2:0] burst_cnt_r;
  logic dqs_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_cnt_r <= 3'h0;
      dqs_r <= 1'b0;
    end else if (is_rd) begin
      burst_cnt_r <= bl8_sel ? BURST8_CLKS : BURST4_CLKS;
      dqs_r <= 1'b0;
    end else if (burst_cnt_r != 3'h0) begin
      burst_cnt_r <= burst_cnt_r - 3'h1;
      dqs_r <= ~dqs_r;
    end else begin
      dqs_r <= 1'b0;
    end
  end

  assign dqs_o = dqs_r;
  assign dqs_oe_o = (burst_cnt_r != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_ROW: assert property (act_o |-> row_o == $past(addr_r))
    else $error("row address not taken on activate");
  AST_AUTOPRE: assert property ((rd_o | wr_o) |-> auto_pre_o == $past(addr_r[AP_BIT]))
    else $error("auto-precharge flag wrong");
  AST_PREALL: assert property (pre_o |-> pre_all_o == $past(addr_r[AP_BIT]))
    else $error("precharge scope wrong");
  AST_OPCODE: assert property (mrs_o |-> opcode_o == $past(addr_r))
    else $error("mode op-code wrong");
  AST_CHOP: assert property ($past(is_rd & (bl_field == BL_OTF)) |-> burst8_o == $past(addr_r[BC_BIT]))
    else $error("on-the-fly chop wrong");
  AST_BANK: assert property ((act_o | rd_o | wr_o | pre_o) |-> bank_o == $past(ba_r))
    else $error("bank select wrong");
  AST_MRSEL: assert property (mrs_o |-> mr_r[mr_sel_o] == 16'(opcode_o))
    else $error("mode register not loaded");
  AST_SAMPLE: assert property ($past(cs_n_i, 2) & !sref_o |-> !(act_o | rd_o | wr_o | pre_o | mrs_o))
    else $error("command taken with chip select high");
  AST_DQS: assert property ((is_rd & bl8_sel) |=> dqs_oe_o [*4] ##1 !dqs_oe_o)
    else $error("strobe burst length wrong");
  AST_MASK: assert property ($past(cs_n_r) |-> !(act_o | rd_o | wr_o | pre_o | ref_o | zq_o))
    else $error("command decoded while deselected");
  AST_DECODE: assert property (is_wr |=> wr_o && !rd_o)
    else $error("write decode wrong");
  AST_SREFX: assert property ((sref_o & cke_i) |=> !sref_o && !pdown_o)
    else $error("self refresh exit missed");

  COV_RD8: cover property (is_rd & bl8_sel ##1 dqs_oe_o [*4]);
  COV_SREF: cover property (sref_o ##[1:20] !sref_o);
  COV_MRS: cover property (mrs_o && mr_sel_o == 2'h0);
  COV_PREALL: cover property (pre_o && pre_all_o);

endmodule : dram_cmd_addr_decode

// >>> dram_cmd_addr_decode_bench.sv
// self-checking bench for the command and address input stage
module dram_cmd_addr_decode_bench
  import dram_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, cke, cs_n, ras_n, cas_n, we_n;
  logic act, rd, wr, pre, pre_all, mrs, rfr, zq, ap, b8, pd, sr, dqs, dqs_oe;
  logic [2:0] ba, bank;
  logic [13:0] addr, row, opc;
  logic [11:0] col;
  logic [1:0] mr_sel, bmode;
  int failures = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  dram_ctl_model ctl (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr));
  dram_cmd_addr_decode DUT (.clk_i(clk), .rst_n_i(rst_n), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr),
    .act_o(act), .rd_o(rd), .wr_o(wr), .pre_o(pre), .pre_all_o(pre_all), .mrs_o(mrs),
    .ref_o(rfr), .zq_o(zq), .bank_o(bank), .row_o(row), .col_o(col), .auto_pre_o(ap),
    .burst8_o(b8), .mr_sel_o(mr_sel), .opcode_o(opc), .burst_mode_o(bmode),
    .pdown_o(pd), .sref_o(sr), .dqs_o(dqs), .dqs_oe_o(dqs_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_mode();
    ctl.issue(CMD_MRS, 3'h0, 14'h0001, 1'b1, 1'b1);
    step(1);
    chk(mrs, 1'b1);
    chk(opc, 14'h0001);
    chk(mr_sel, 2'h0);
    chk(bmode, BL_OTF);
    ctl.issue(CMD_MRS, 3'h2, 14'h1234, 1'b1, 1'b1);
    step(1);
    chk(mr_sel, 2'h2);
    chk(opc, 14'h1234);
    $display("test mode done");
  endtask : t_mode
  task automatic t_act();
    ctl.issue(CMD_ACT, 3'h5, 14'h2abc, 1'b1, 1'b1);
    step(1);
    chk(act, 1'b1);
    chk(row, 14'h2abc);
    chk(bank, 3'h5);
    ctl.issue(CMD_ACT, 3'h1, 14'h0155, 1'b1, 1'b0);
    step(1);
    chk(act, 1'b0);
    chk(row, 14'h2abc);
    $display("test activate done");
  endtask : t_act
  task automatic t_rw(input logic [2:0] cmd, input logic [13:0] a, input logic [11:0] c,
                      input logic p, input logic b, input int n);
    int k;
    int h;
    ctl.issue(cmd, 3'h3, a, 1'b1, 1'b1);
    step(1);
    chk({rd, wr}, {cmd == CMD_RD, cmd == CMD_WR});
    chk(col, c);
    chk(ap, p);
    chk(b8, b);
    chk(bank, 3'h3);
    k = 0;
    h = 0;
    repeat (8) begin
      if (dqs_oe === 1'b1) k++;
      if (dqs_oe === 1'b1 && dqs === 1'b1) h++;
      step(1);
    end
    chk(k[15:0], n[15:0]);
    chk(h[15:0], 16'(n / 2));
    $display("test access done");
  endtask : t_rw
  task automatic t_pre();
    ctl.issue(CMD_PRE, 3'h6, 14'h0000, 1'b1, 1'b1);
    step(1);
    chk({pre, pre_all, bank}, {2'b10, 3'h6});
    ctl.issue(CMD_PRE, 3'h1, 14'h0400, 1'b1, 1'b1);
    step(1);
    chk({pre, pre_all}, 2'b11);
    $display("test precharge done");
  endtask : t_pre
  task automatic t_cmds();
    ctl.issue(CMD_REF, 3'h0, 14'h0000, 1'b1, 1'b1);
    step(1);
    chk({rfr, zq}, 2'b10);
    ctl.issue(CMD_ZQ, 3'h0, 14'h0400, 1'b1, 1'b1);
    step(1);
    chk({rfr, zq}, 2'b01);
    ctl.issue(CMD_ZQ, 3'h0, 14'h0400, 1'b1, 1'b0);
    step(1);
    chk({rfr, zq}, 2'b00);
    ctl.issue(CMD_MRS, 3'h4, 14'h0002, 1'b1, 1'b1);
    step(1);
    chk({mrs, opc}, {1'b0, 14'h1234});
    chk(bmode, BL_OTF);
    $display("test refresh and calibration done");
  endtask : t_cmds
  task automatic t_fixed();
    ctl.issue(CMD_MRS, 3'h0, 14'(BL_FIXED4), 1'b1, 1'b1);
    step(1);
    chk(bmode, BL_FIXED4);
    t_rw(CMD_RD, 14'h1000, 12'h000, 1'b0, 1'b0, BURST4_CLKS);
    ctl.issue(CMD_MRS, 3'h0, 14'(BL_FIXED8), 1'b1, 1'b1);
    step(1);
    chk(bmode, BL_FIXED8);
    t_rw(CMD_RD, 14'h0000, 12'h000, 1'b0, 1'b1, BURST8_CLKS);
    $display("test fixed burst done");
  endtask : t_fixed
  task automatic t_power();
    ctl.issue(CMD_NOP, 3'h0, 14'h0000, 1'b0, 1'b0);
    step(3);
    chk(pd, 1'b1);
    ctl.issue(CMD_ACT, 3'h2, 14'h0011, 1'b0, 1'b1);
    step(1);
    chk(act, 1'b0);
    ctl.issue(CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0);
    step(3);
    chk(pd, 1'b0);
    ctl.issue(CMD_REF, 3'h0, 14'h0000, 1'b0, 1'b1);
    step(2);
    chk({sr, pd}, 2'b10);
    ctl.issue(CMD_NOP, 3'h0, 14'h0000, 1'b1, 1'b0);
    step(3);
    chk(sr, 1'b0);
    $display("test power done");
  endtask : t_power
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    step(4);
    t_mode();
    t_act();
    t_rw(CMD_RD, 14'h0404, 12'h004, 1'b1, 1'b0, BURST4_CLKS);
    t_rw(CMD_RD, 14'h1400, 12'h000, 1'b1, 1'b1, BURST8_CLKS);
    t_rw(CMD_WR, 14'h2001, 12'h801, 1'b0, 1'b0, 0);
    t_pre();
    t_cmds();
    t_fixed();
    t_power();
    conclude();
  end
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : dram_cmd_addr_decode_bench

// >>> dram_cmd_pkg.sv
// constants for the command and address input stage of a synchronous dram
// Behaviour
// - ACTIVATE takes address as row; READ/WRITE take column, A10 is auto-precharge.
// - PRECHARGE samples A10: low closes addressed bank, high closes all banks.
// - LOAD MODE takes the address lines as the mode register op-code.
// - with on-the-fly chop enabled, A12 high gives burst 8, low burst 4.
// - the bank address picks the bank for ACTIVATE, READ, WRITE, PRECHARGE.
// - during LOAD MODE the bank address picks one of four mode registers.
// - every address and control input is sampled at the rising clock edge; the code takes self refresh exit from cke_i unsampled.
// - the output data strobe is timed from the clock edges.
// - chip select registered high masks every command.
// - the command is decoded from RAS, CAS, WE with chip select.
// - clock enable is sampled for power-down entry and exit and self refresh entry; self refresh exit unsampled.
package dram_cmd_pkg;
  // command codes on {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_ZQ = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // address bit positions
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // burst length field of mode register 0
  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // strobe clocks per burst: two data beats per clock
  localparam logic [2:0] BURST8_CLKS = 3'h4;
  localparam logic [2:0] BURST4_CLKS = 3'h2;
  // reset values
  localparam logic [15:0] MR_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_PDOWN = 2'b01,
    ST_SREF = 2'b11
  } pwr_state_e;
endpackage : dram_cmd_pkg

// >>> dram_ctl_model.sv
// memory controller model driving the command and address pins
module dram_ctl_model
  import dram_cmd_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input wire logic clk_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [ADDR_W-1:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = CMD_NOP;
    ba_o = 3'h0;
    addr_o = '0;
  end
  // one command for one clock, then deselect with NOP; bank and address lines show the inverse
  task automatic issue(input logic [2:0] cmd, input logic [2:0] ba,
                       input logic [ADDR_W-1:0] a, input logic ck, input logic sel);
    @(posedge clk_i);
    cs_n_o <= ~sel;
    {ras_n_o, cas_n_o, we_n_o} <= cmd;
    ba_o <= ba;
    addr_o <= a;
    cke_o <= ck;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    {ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
    ba_o <= ~ba;
    addr_o <= ~a;
  endtask : issue
endmodule : dram_ctl_model
